/* hdl/driver_chain_datagram_sequencer.sv */
// serial driver chain datagram sequencer with APB register and RAM access
`timescale 1ns/100ps
module driver_chain_datagram_sequencer
(
  input  wire logic        core_clk_i,            // system clock
  input  wire logic        nrst_i,                // async reset, active low
  input  wire logic        psel_i,                // apb select
  input  wire logic        penable_i,             // apb enable
  input  wire logic        pwrite_i,              // apb direction
  input  wire logic [11:0] paddr_i,               // apb byte address
  input  wire logic [31:0] pwdata_i,              // apb write data
  output logic      [31:0] prdata_o,              // apb read data
  output logic             pready_o,              // apb ready
  output logic             pslverr_o,             // apb error
  input  wire logic        datagram_request_i,    // send request pulse
  input  wire logic [17:0] coil_a_dac_i,          // 6 bits per motor
  input  wire logic [2:0]  coil_a_phase_i,        // per motor
  input  wire logic [2:0]  coil_a_fast_decay_i,   // per motor
  input  wire logic [17:0] coil_b_dac_i,          // 6 bits per motor
  input  wire logic [2:0]  coil_b_phase_i,        // per motor
  input  wire logic [2:0]  coil_b_fast_decay_i,   // per motor
  input  wire logic [2:0]  direction_i,           // per motor
  input  wire logic [2:0]  step_i,                // per motor
  input  wire logic [7:0]  ustep_index_i,         // full period position
  output logic      [6:0]  wave_sin_o,            // sign and magnitude
  output logic      [6:0]  wave_cos_o,            // shifted by 90 degrees
  input  wire logic        chain_serial_in,       // data from chain
  output logic             chain_serial_out,      // data to chain
  output logic             chain_clk_o,           // chain serial clock
  output logic             chain_select_n,        // chain select
  output logic             step_dir_mode_select_o // step/dir mode active
);
  import chain_seq_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [2*WORD_W-1:0] ram_q [RAM_DEPTH];

  logic                step_dir_mode_select_q;
  logic                cs_pol_q;
  logic                ck_pol_q;
  logic [7:0]          clkdiv_q;
  logic [1:0]          last_driver_index_q;
  logic [31:0]         rx_shift_q;
  logic [31:0]         prdata_q;
  logic                pready_q;
  logic                pslverr_q;
  logic                start_q;

  chain_state_t        state_q;
  logic [7:0]          half_cnt_q;
  logic [5:0]          word_ptr_q;
  logic [1:0]          motor_q;
  logic                dout_q;
  logic                sck_q;
  logic                sel_n_q;
  logic [6:0]          sin_q;
  logic [6:0]          cos_q;

  // snapshot of sequencer outputs, 20 signals per motor
  logic [19:0]         snap_q [3];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] word_of(input logic [5:0] ptr);
    logic [11:0] pair;
    pair = ram_q[{1'b0, ptr[5:1]}];
    word_of = ptr[0] ? pair[11:6] : pair[5:0];
  endfunction

  function automatic logic code_bit(input logic [4:0] code, input logic [19:0] sig);
    code_bit = 1'b0;
    if (code <= CODE_STEP)
      code_bit = sig[code];
  endfunction

  function automatic logic [31:0] status_word(input logic busy, input logic [1:0] mot,
                                              input logic [5:0] ptr);
    status_word                    = 32'h0000_0000;
    status_word[STAT_BUSY_BIT]     = busy;
    status_word[STAT_MOT_LSB +: 2] = mot;
    status_word[STAT_PTR_LSB +: 6] = ptr;
  endfunction

  function automatic logic [6:0] wave_of(input logic [7:0] idx);
    logic [5:0]  pos;
    logic [5:0]  entry;
    logic [11:0] pair;
    pos   = idx[6] ? ~idx[5:0] : idx[5:0];
    pair  = ram_q[{1'b1, pos[5:1]}];
    entry = pos[0] ? pair[11:6] : pair[5:0];
    wave_of = {idx[7], entry};
  endfunction

  logic        apb_setup;
  logic        apb_wr;
  logic        is_ram;
  logic [5:0]  cur_word;
  logic        half_done;
  logic        end_of_gram;
  logic        start_req;

  assign apb_setup   = psel_i && !penable_i;
  assign apb_wr      = psel_i && penable_i && pready_q && pwrite_i;
  assign is_ram      = paddr_i[RAM_SEL_BIT];
  assign cur_word    = word_of(word_ptr_q);
  assign half_done   = (half_cnt_q == clkdiv_q);
  assign end_of_gram = cur_word[NXM_BIT] && (motor_q == last_driver_index_q);
  assign start_req   = (start_q || datagram_request_i) && !step_dir_mode_select_q;

  // ----------------------------------------------------------------
  // apb slave: answer in the first access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= apb_setup;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      if (apb_setup)
      begin
        if (paddr_i[1:0] != 2'h0 || paddr_i[11:9] != 3'h0)
          pslverr_q <= 1'b1;
        else if (is_ram)
          prdata_q <= {20'h00000, ram_q[paddr_i[7:2]]};
        else
        begin
          unique case (paddr_i)
            CTRL_OFS:    prdata_q <= {29'h0, ck_pol_q, cs_pol_q, step_dir_mode_select_q};
            CLKDIV_OFS:  prdata_q <= {24'h000000, clkdiv_q};
            LASTDRV_OFS: prdata_q <= {30'h0, last_driver_index_q};
            STATUS_OFS:  prdata_q <= status_word(state_q != ST_IDLE, motor_q, word_ptr_q);
            RXDATA_OFS:  prdata_q <= rx_shift_q;
            default:     pslverr_q <= 1'b1;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      step_dir_mode_select_q <= SD_RST;
      cs_pol_q               <= 1'b0;
      ck_pol_q               <= 1'b0;
      clkdiv_q               <= CLKDIV_RST;
      last_driver_index_q    <= LASTDRV_RST;
      start_q                <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      if (apb_wr && !is_ram && !pslverr_q)
      begin
        if (paddr_i == CTRL_OFS)
        begin
          step_dir_mode_select_q <= pwdata_i[CTRL_SD_BIT];
          cs_pol_q               <= pwdata_i[CTRL_CSPOL_BIT];
          ck_pol_q               <= pwdata_i[CTRL_CKPOL_BIT];
          start_q                <= pwdata_i[CTRL_START_BIT];
        end
        if (paddr_i == CLKDIV_OFS)
          clkdiv_q <= (pwdata_i[7:0] < CLKDIV_MIN) ? CLKDIV_MIN : pwdata_i[7:0];
        if (paddr_i == LASTDRV_OFS)
          last_driver_index_q <= pwdata_i[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // on-chip RAM, writable at any time
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (apb_wr && is_ram && !pslverr_q)
      ram_q[paddr_i[7:2]] <= pwdata_i[11:0];
  end

  // ----------------------------------------------------------------
  // microstep wave expansion
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sin_q <= 7'h00;
      cos_q <= 7'h00;
    end
    else
    begin
      sin_q <= wave_of(ustep_index_i);
      cos_q <= wave_of(ustep_index_i + 8'h40);
    end
  end

  // ----------------------------------------------------------------
  // sequencer snapshot
  // ----------------------------------------------------------------
  generate
    for (genvar m = 0; m < 3; m++)
    begin : g_snap
      always_ff @(posedge core_clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
          snap_q[m] <= 20'h00000;
        else if (state_q == ST_IDLE && start_req)
          snap_q[m] <= {step_i[m], direction_i[m], 1'b1, 1'b0,
                        coil_b_fast_decay_i[m], coil_b_phase_i[m], coil_b_dac_i[6*m +: 6],
                        coil_a_fast_decay_i[m], coil_a_phase_i[m],
                        coil_a_dac_i[6*m +: 6]};
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      half_cnt_q <= 8'h00;
    else if (state_q == ST_IDLE || half_done)
      half_cnt_q <= 8'h00;
    else
      half_cnt_q <= half_cnt_q + 8'h01;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q    <= ST_IDLE;
      word_ptr_q <= 6'h00;
      motor_q    <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          word_ptr_q <= 6'h00;
          motor_q    <= 2'h0;
          if (start_req)
            state_q <= ST_LOW;
        end
        ST_LOW:
        begin
          if (half_done)
            state_q <= ST_HIGH;
        end
        ST_HIGH:
        begin
          if (half_done)
          begin
            if (end_of_gram)
            begin
              motor_q <= 2'h0;
              state_q <= ST_HOLD;
            end
            else
            begin
              if (cur_word[NXM_BIT])
                motor_q <= motor_q + 2'h1;
              word_ptr_q <= word_ptr_q + 6'h01;
              state_q    <= ST_LOW;
            end
          end
        end
        ST_HOLD:
        begin
          if (half_done)
            state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pins: data changes on the trailing edge, input caught on trailing
  // ----------------------------------------------------------------
  // data pin, low while idle
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      dout_q <= 1'b0;
    else if (state_q == ST_IDLE)
      dout_q <= 1'b0;
    else
      dout_q <= code_bit(cur_word[4:0], snap_q[motor_q]);
  end

  // clock pin, active only in the high phase
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sck_q <= 1'b0;
    else
      sck_q <= (state_q == ST_HIGH) ^ ck_pol_q;
  end

  // select pin, active from start to end of hold
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sel_n_q <= 1'b1;
    else
      sel_n_q <= (state_q == ST_IDLE) ^ cs_pol_q;
  end

  // returning data, caught at the end of each high phase
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rx_shift_q <= 32'h0000_0000;
    else if (state_q == ST_HIGH && half_done)
      rx_shift_q <= {rx_shift_q[30:0], chain_serial_in};
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o               = prdata_q;
  assign pready_o               = pready_q;
  assign pslverr_o              = pslverr_q;
  assign wave_sin_o             = sin_q;
  assign wave_cos_o             = cos_q;
  assign chain_serial_out       = dout_q;
  assign chain_clk_o            = sck_q;
  assign chain_select_n         = sel_n_q;
  assign step_dir_mode_select_o = step_dir_mode_select_q;

endmodule // driver_chain_datagram_sequencer

/* hdl/chain_seq_pkg.sv */
// constants and register map of the driver chain datagram sequencer
// ----------------------------------------------------------------
// Summary of operation
// - lower 32 RAM addresses hold chain configuration
// - chain mode only when step/dir select cleared
// - farthest driver shifted first is driver 0
// - datagrams generated autonomously after initialization
// - serial period 16 to 512 system clocks
// - reset period 32 clocks, 16 per phase
// - divider value 7 gives 16-clock period
// - select and clock polarity programmable
// - datagram carries 1 to 64 bits
// - 5-bit code selects one sequencer signal
// - bits sent in stored code order
// - RAM is 64 addresses of two 6-bit words
// - select bit 0 registers, 1 RAM
// - odd word upper six, even lower six
// - word is next-motor marker plus code
// - reading starts at first configuration address
// - upper 32 addresses hold shared microstep table
// - quarter table expanded, plus 90 degree copy
// - marker set advances to next driver
// - marker at last driver ends, counter cleared
// - on demand, sequencer outputs snapshotted first
// - no marker means endless transmission
// - signal code decode table
// - aligned RAM access always accepted
// ----------------------------------------------------------------
package chain_seq_pkg;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] CLKDIV_OFS   = 12'h004;
  localparam logic [11:0] LASTDRV_OFS  = 12'h008;
  localparam logic [11:0] STATUS_OFS   = 12'h00c;
  localparam logic [11:0] RXDATA_OFS   = 12'h010;
  localparam int          RAM_SEL_BIT  = 8;

  // control fields
  localparam int CTRL_SD_BIT    = 0;
  localparam int CTRL_CSPOL_BIT = 1;
  localparam int CTRL_CKPOL_BIT = 2;
  localparam int CTRL_START_BIT = 3;

  // status fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_MOT_LSB   = 1;
  localparam int STAT_PTR_LSB   = 3;

  // reset values and limits
  localparam logic [7:0] CLKDIV_RST   = 8'h0f;
  localparam logic [7:0] CLKDIV_MIN   = 8'h07;
  localparam logic [1:0] LASTDRV_RST  = 2'h2;
  localparam logic       SD_RST       = 1'b0;

  // RAM geometry
  localparam int WORD_W     = 6;
  localparam int RAM_DEPTH  = 64;
  localparam int CFG_DEPTH  = 32;
  localparam int NXM_BIT    = 5;

  // signal codes
  localparam logic [4:0] CODE_ZERO = 5'h10;
  localparam logic [4:0] CODE_ONE  = 5'h11;
  localparam logic [4:0] CODE_DIR  = 5'h12;
  localparam logic [4:0] CODE_STEP = 5'h13;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_HOLD
  } chain_state_t;

endpackage

/* tb/chain_seq_properties.sv */
// concurrent checks on the sequencer ports
`timescale 1ns/100ps
module chain_seq_properties
  import chain_seq_pkg::*;
(
  input wire logic        core_clk_i,            // clock
  input wire logic        nrst_i,                // reset
  input wire logic        psel_i,                // apb
  input wire logic        penable_i,             // apb
  input wire logic        pwrite_i,              // apb
  input wire logic [11:0] paddr_i,               // apb
  input wire logic [31:0] pwdata_i,              // apb
  input wire logic [31:0] prdata_o,              // apb
  input wire logic        pready_o,              // apb
  input wire logic        pslverr_o,             // apb
  input wire logic        chain_serial_out,      // link
  input wire logic        chain_clk_o,           // link
  input wire logic        chain_select_n,        // link
  input wire logic        step_dir_mode_select_o // mode
);
  logic [9:0] cnt_q;
  logic [8:0] half_q;
  logic [2:0] quiet_q;
  logic       cs_pol_q;
  logic       ck_pol_q;
  logic       clk_p_q;
  logic       sel_p_q;
  wire        wr       = psel_i && penable_i && pready_o && pwrite_i;
  wire        setup    = psel_i && !penable_i;
  wire        clk_chg  = chain_clk_o != clk_p_q;
  wire        sel_chg  = chain_select_n != sel_p_q;
  wire        idle_sel = chain_select_n == !cs_pol_q;
  wire        calm     = quiet_q == 3'h0;

  // ----------------------------------------
  // shadow of settings, quiet after ctrl write
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      half_q   <= 9'(CLKDIV_RST) + 9'h1;
      cs_pol_q <= 1'b0;
      ck_pol_q <= 1'b0;
      quiet_q  <= 3'h0;
    end
    else
    begin
      quiet_q <= calm ? 3'h0 : quiet_q - 3'h1;
      if (wr && paddr_i == CTRL_OFS)
      begin
        cs_pol_q <= pwdata_i[CTRL_CSPOL_BIT];
        ck_pol_q <= pwdata_i[CTRL_CKPOL_BIT];
        quiet_q  <= 3'h4;
      end
      if (wr && paddr_i == CLKDIV_OFS)
        half_q <= 9'((pwdata_i[7:0] < CLKDIV_MIN) ? CLKDIV_MIN : pwdata_i[7:0]) + 9'h1;
    end
  end

  // cycles since the last link edge
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q   <= 10'h0;
      clk_p_q <= 1'b0;
      sel_p_q <= 1'b1;
    end
    else
    begin
      clk_p_q <= chain_clk_o;
      sel_p_q <= chain_select_n;
      cnt_q   <= (clk_chg || sel_chg) ? 10'h1 : cnt_q + 10'h1;
    end
  end

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_start;
    setup ##1 wr && paddr_i == CTRL_OFS && pwdata_i[CTRL_START_BIT]
      && !pwdata_i[CTRL_SD_BIT] && !step_dir_mode_select_o
      && pwdata_i[CTRL_CSPOL_BIT] == cs_pol_q && idle_sel;
  endsequence

  chk_ram_accept:
    assert property (setup && paddr_i[RAM_SEL_BIT] && paddr_i[11:9] == 3'h0
      && paddr_i[1:0] == 2'h0 |=> pready_o && !pslverr_o)
    else $error("ram access refused");
  chk_err_decode:
    assert property (setup && paddr_i[1:0] != 2'h0 |=> pready_o && pslverr_o
      && prdata_o == 32'h0)
    else $error("misaligned access not refused");
  chk_bit_period:
    assert property (clk_chg && calm |-> cnt_q == 10'(half_q))
    else $error("serial clock phase length wrong");
  chk_sel_release:
    assert property (sel_chg && idle_sel && calm |-> cnt_q == 10'(half_q)
      && chain_clk_o == ck_pol_q)
    else $error("select released too early");
  chk_start_select:
    assert property (s_start |-> ##[1:3] !idle_sel)
    else $error("start did not select chain");
  chk_mode_idle:
    assert property (step_dir_mode_select_o && calm |-> idle_sel)
    else $error("chain active in step dir mode");
  chk_data_edge:
    assert property ($changed(chain_serial_out) && !sel_chg && !idle_sel && calm
      |-> clk_chg && chain_clk_o == ck_pol_q)
    else $error("data changed on wrong clock edge");
  chk_clk_idle:
    assert property (idle_sel && calm |-> chain_clk_o == ck_pol_q)
    else $error("serial clock not at idle level");
endmodule // chain_seq_properties

bind driver_chain_datagram_sequencer chain_seq_properties u_props
(
  .core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .chain_serial_out, .chain_clk_o,
  .chain_select_n, .step_dir_mode_select_o
);

/* tb/chain_driver_model.sv */
// behavioural driver chain on the serial link
`timescale 1ns/100ps
module chain_driver_model
(
  input  wire logic        cs_pol_i,   // select active high
  input  wire logic        ck_pol_i,   // clock idle high
  input  wire logic        select_n_i, // chain select
  input  wire logic        sclk_i,     // serial clock
  input  wire logic        sdata_i,    // data from block
  output logic             sdata_o,    // data to block
  output logic      [63:0] rx_o,       // received bits
  output logic      [6:0]  count_o     // received count
);
  wire  act    = select_n_i == cs_pol_i;
  logic act_n;
  logic act_p  = 1'b0;
  logic sclk_p = 1'b0;

  // ----------------------------------------
  // capture and answer
  // ----------------------------------------
  // cleared on selection; first bit ends up on top, leading edge capture
  always @(select_n_i or sclk_i or cs_pol_i)
  begin
    act_n = (select_n_i == cs_pol_i);
    if (act_n && !act_p)
    begin
      rx_o    = 64'h0;
      count_o = 7'h0;
    end
    else if (act_n && sclk_i != sclk_p && sclk_i != ck_pol_i)
    begin
      rx_o    = {rx_o[62:0], sdata_i};
      count_o = count_o + 7'h1;
    end
    act_p  = act_n;
    sclk_p = sclk_i;
  end

  // inverted echo, pull-up while deselected
  assign sdata_o = act ? ~rx_o[0] : 1'b1;
endmodule // chain_driver_model

/* tb/driver_chain_datagram_sequencer_test.sv */
// self-checking bench of the driver chain datagram sequencer
`timescale 1ns/100ps
`define check_eq(g, x) \
  begin \
    n_checks++; \
    if ((g) !== (x)) \
    begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x); \
    end \
  end
module driver_chain_datagram_sequencer_test;
  import chain_seq_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        nrst_i     = 1'b0;
  logic        psel       = 1'b0;
  logic        pen        = 1'b0;
  logic        pwr        = 1'b0;
  logic [11:0] pa         = 12'h0;
  logic [31:0] pwd        = 32'h0;
  logic        req        = 1'b0;
  logic        cs_pol     = 1'b0;
  logic        ck_pol     = 1'b0;
  logic [7:0]  ustep      = 8'h00;
  logic [6:0]  wsin;
  logic [6:0]  wcos;
  logic [53:0] mot        = {3'h1, 3'h3, 24'h0, 3'h0, 3'h2, 18'h3fffe};
  logic [31:0] prd;
  logic        rdy;
  logic        err;
  logic        sdi;
  logic        sdo;
  logic        sclk;
  logic        seln;
  logic        mode;
  logic [63:0] rx;
  logic [6:0]  cnt;
  int          n_errors   = 0;
  int          n_checks   = 0;

  always #5 core_clk_i = ~core_clk_i;

  driver_chain_datagram_sequencer uut
  (
    .core_clk_i, .nrst_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
    .datagram_request_i(req), .coil_a_dac_i(mot[17:0]), .coil_a_phase_i(mot[20:18]),
    .coil_a_fast_decay_i(mot[23:21]), .coil_b_dac_i(mot[41:24]),
    .coil_b_phase_i(mot[44:42]), .coil_b_fast_decay_i(mot[47:45]),
    .direction_i(mot[50:48]), .step_i(mot[53:51]), .ustep_index_i(ustep),
    .wave_sin_o(wsin), .wave_cos_o(wcos), .chain_serial_in(sdi), .chain_serial_out(sdo),
    .chain_clk_o(sclk), .chain_select_n(seln), .step_dir_mode_select_o(mode)
  );

  chain_driver_model u_chain
  (
    .cs_pol_i(cs_pol), .ck_pol_i(ck_pol), .select_n_i(seln), .sclk_i(sclk),
    .sdata_i(sdo), .sdata_o(sdi), .rx_o(rx), .count_o(cnt)
  );

  // ----------------------------------------
  // bus and run control
  // ----------------------------------------
  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic time_out();
    n_errors++;
    print_verdict();
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge core_clk_i);
    pen <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge core_clk_i);
      if (rdy === 1'b1)
        break;
    end
    if (n == 16)
      time_out();
    r = prd;
    e = err;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `check_eq(r, x)
    `check_eq(e, xe)
  endtask

  task automatic pulse_req();
    @(posedge core_clk_i);
    req <= 1'b1;
    @(posedge core_clk_i);
    req <= 1'b0;
  endtask

  // one datagram, inputs flipped once it is under way
  task automatic run_dg(input logic by_reg);
    int          n;
    logic [31:0] r;
    logic        e;
    if (by_reg)
      wr(CTRL_OFS, {28'h0, 1'b1, ck_pol, cs_pol, 1'b0});
    else
      pulse_req();
    for (n = 0; n < 40 && seln !== cs_pol; n++)
      @(posedge core_clk_i);
    if (n == 40)
      time_out();
    mot <= ~mot;
    pulse_req();
    rd_chk(12'h100, 32'h11, 1'b0);
    for (n = 0; n < 3000 && seln !== !cs_pol; n++)
      @(posedge core_clk_i);
    if (n == 3000)
      time_out();
    `check_eq(cnt, 7'h5)
    `check_eq(rx[4:0], 5'h16)
    mot <= ~mot;
    repeat (100) @(posedge core_clk_i);
    `check_eq(seln, !cs_pol)
    apb(1'b0, STATUS_OFS, 32'h0, r, e);
    `check_eq(r[2:0], 3'h0)
    apb(1'b0, RXDATA_OFS, 32'h0, r, e);
    `check_eq(r[4:0], 5'h09)
  endtask

  task automatic t_reset();
    rd_chk(CTRL_OFS, 32'h0, 1'b0);
    rd_chk(CLKDIV_OFS, 32'hf, 1'b0);
    rd_chk(LASTDRV_OFS, 32'h2, 1'b0);
    `check_eq({seln, sclk, mode}, 3'h4)
  endtask

  task automatic t_ram();
    wr(12'h100, 32'hfff00011);
    wr(12'h104, 32'h9b3);
    wr(12'h108, 32'h32);
    wr(12'h1fc, 32'hfff);
    rd_chk(12'h100, 32'h11, 1'b0);
    rd_chk(12'h104, 32'h9b3, 1'b0);
    rd_chk(12'h1fc, 32'hfff, 1'b0);
    rd_chk(12'h014, 32'h0, 1'b1);
    rd_chk(12'h102, 32'h0, 1'b1);
  endtask

  // table T0=3, T1=5, T62=T63=3f; sign on bit7, mirror on bit6
  task automatic t_wave();
    wr(12'h180, 32'h143);
    ustep <= 8'h00;
    repeat (3) @(posedge core_clk_i);
    `check_eq({wsin, wcos}, 14'h01bf)
    ustep <= 8'h81;
    repeat (3) @(posedge core_clk_i);
    `check_eq({wsin, wcos}, 14'h22ff)
    ustep <= 8'h7f;
    repeat (3) @(posedge core_clk_i);
    `check_eq({wsin, wcos}, 14'h01ff)
  endtask

  // no marker anywhere: sends ones past the wrap until a reset
  task automatic t_endless();
    int i;
    for (i = 0; i < 32; i++)
      wr(12'h100 + 12'(4 * i), 32'h451);
    pulse_req();
    repeat (1200) @(posedge core_clk_i);
    `check_eq({seln, cnt > 7'h42, rx[3:0]}, 6'h1f)
    nrst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    `check_eq({seln, sclk, sdo}, 3'h4)
    nrst_i <= 1'b1;
    rd_chk(CLKDIV_OFS, 32'hf, 1'b0);
    rd_chk(STATUS_OFS, 32'h0, 1'b0);
    wr(12'h100, 32'h011);
    wr(12'h104, 32'h9b3);
    wr(12'h108, 32'h032);
  endtask

  task automatic t_chain();
    run_dg(1'b0);
    wr(CLKDIV_OFS, 32'h3);
    rd_chk(CLKDIV_OFS, 32'h7, 1'b0);
    run_dg(1'b1);
  endtask

  task automatic t_mode();
    wr(CTRL_OFS, 32'h1);
    pulse_req();
    repeat (60) @(posedge core_clk_i);
    `check_eq({mode, seln}, 2'h3)
    wr(CTRL_OFS, 32'h6);
    cs_pol <= 1'b1;
    ck_pol <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    `check_eq({seln, sclk, mode}, 3'h2)
    run_dg(1'b0);
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_ram();
    t_wave();
    t_chain();
    t_endless();
    t_mode();
    print_verdict();
  end
endmodule // driver_chain_datagram_sequencer_test
